// *** include/sector_guard_pkg.sv ***
// Purpose: constants and types for the rf sector password guard
// Assumes: four sectors, three 32-bit passwords, 512-byte i2c user area
// Notes: offsets are block indices of the password system area
package sector_guard_pkg;
    localparam int unsigned NUM_SECTORS = 4;
    localparam int unsigned NUM_PASSWORDS = 3;
    localparam logic [1:0] OFS_GUARD_WORD = 2'h0;
    localparam logic [1:0] OFS_PASSWORD_ONE = 2'h1;
    localparam logic [1:0] OFS_PASSWORD_TWO = 2'h2;
    localparam logic [1:0] OFS_PASSWORD_THREE = 2'h3;
    localparam logic [7:0] GUARD_BYTE_RESET = 8'h00;
    localparam logic [31:0] PASSWORD_RESET = 32'h0000_0000;
    localparam int unsigned LOCK_BIT = 0;
    localparam int unsigned PROT_LSB = 1;
    localparam int unsigned SEL_LSB = 3;
    localparam logic [7:0] GUARD_USED_MASK = 8'h1f;
    localparam int unsigned SECTOR_BYTES = 128;
    localparam int unsigned SECTOR_SHIFT = 7;
    localparam int unsigned SECTOR_BLOCK_SHIFT = 5;
    localparam logic [1:0] PROT_RO_NOPW = 2'h0;
    localparam logic [1:0] PROT_OPEN = 2'h1;
    localparam logic [1:0] PROT_PW_RW = 2'h2;
    localparam logic [1:0] PROT_PW_RO = 2'h3;
    localparam logic [1:0] SEL_NONE = 2'h0;

    typedef enum logic [2:0] {
        RF_NONE = 3'b000,
        RF_READ = 3'b001,
        RF_WRITE = 3'b010,
        RF_LOCK = 3'b011,
        RF_PW_WRITE = 3'b100,
        RF_PW_PRESENT = 3'b101
    } rf_cmd_t;

    typedef struct packed {
        logic valid;
        rf_cmd_t cmd;
        logic [6:0] block;
        logic [1:0] sel;
        logic [3:0] lock_bits;
        logic option;
        logic [31:0] data;
    } rf_req_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic read_ok;
        logic write_ok;
        logic with_guard;
        logic [7:0] guard;
    } rf_rsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic area_select_bit;
        logic [8:0] addr;
        logic [7:0] wdata;
        logic pw_ok;
    } i2c_req_t;

    typedef struct packed {
        logic valid;
        logic ok;
        logic write_ok;
        logic [7:0] rdata;
    } i2c_rsp_t;
endpackage : sector_guard_pkg

// *** rtl/rf_sector_password_guard.sv ***
// Purpose: rf/i2c access decisions for a four-sector password-guarded tag
// Assumes: command decoders upstream deliver one-cycle request strobes
// Notes: memory array itself lives outside; this block only decides
//
// Summary of operation
// - guard byte: lock, protect code, password selector
// - all guard bytes zero at delivery
// - option flag read returns guard byte
// - unlocked sector allows read and write
// - locked sector access follows protect code table
// - selector picks none, password one, two, three
// - three passwords at block addresses one to three
// - password write stores value, active after write
// - password change needs prior valid present
// - passwords start all zero and active
// - lock writes bits four to one, sets lock
// - lock of locked sector returns error
// - correct present grants linked sectors rights
// - wrong present withdraws all granted rights
// - i2c reads guard area freely, writes need password
// - i2c guard write reinitialises rf access
// - each i2c sector spans 128 bytes
`timescale 1ns/1ps
`default_nettype none
module rf_sector_password_guard (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire sector_guard_pkg::rf_req_t i_rf_req,
    input wire sector_guard_pkg::i2c_req_t i_i2c_req,
    output var sector_guard_pkg::rf_rsp_t o_rf_rsp,
    output var sector_guard_pkg::i2c_rsp_t o_i2c_rsp,
    output logic [31:0] o_guard_word
);
    import sector_guard_pkg::*;

    logic [7:0] guard [NUM_SECTORS];
    logic [31:0] password [NUM_PASSWORDS];
    logic [NUM_PASSWORDS-1:0] granted;

    // sector access by protect code, lock and presented state
    function automatic logic [1:0] access_rw(input logic [7:0] g,
                                             input logic [2:0] gr);
        logic [1:0] sel;
        logic pres;
        logic [1:0] prot;
        sel = g[SEL_LSB +: 2];
        prot = g[PROT_LSB +: 2];
        pres = (sel != SEL_NONE) && gr[sel - 2'h1];
        if (!g[LOCK_BIT]) begin
            access_rw = 2'b11;
        end else if (pres) begin
            access_rw = (prot == PROT_PW_RO) ? 2'b10 : 2'b11;
        end else if (prot == PROT_RO_NOPW) begin
            access_rw = 2'b10;
        end else if (prot == PROT_OPEN) begin
            access_rw = 2'b11;
        end else begin
            access_rw = 2'b00;
        end
    endfunction : access_rw

    wire rf_go = i_ce && i_rf_req.valid;
    wire [1:0] rf_sector = i_rf_req.block[6:SECTOR_BLOCK_SHIFT];
    wire [7:0] rf_guard = guard[rf_sector];
    wire [1:0] rf_acc = access_rw(rf_guard, granted);
    wire rf_pw_block = (i_rf_req.block[6:2] == 5'h00) &&
                       (i_rf_req.block[1:0] != OFS_GUARD_WORD);
    wire [1:0] rf_pw_idx = i_rf_req.block[1:0] - 2'h1;
    wire rf_pw_hit = rf_pw_block &&
                     (i_rf_req.data == password[rf_pw_idx]);
    wire rf_lock_ok = !guard[i_rf_req.sel][LOCK_BIT];
    wire rf_pw_wr_ok = rf_pw_block && granted[rf_pw_idx];
    wire [1:0] i2c_sector = i_i2c_req.addr[8:SECTOR_SHIFT];
    wire [1:0] i2c_acc = access_rw(guard[i2c_sector], granted);
    wire i2c_go = i_ce && i_i2c_req.valid;
    wire i2c_guard_area = i_i2c_req.area_select_bit &&
                          (i_i2c_req.addr[8:2] == 7'h00);
    wire i2c_guard_wr = i2c_go && i_i2c_req.write && i2c_guard_area &&
                        i_i2c_req.pw_ok;
    wire [7:0] i2c_guard_rd = guard[i_i2c_req.addr[1:0]];
    wire [1:0] i2c_byte = i_i2c_req.addr[1:0];
    // only a same-sector clash drops the lock; other sectors lock as asked
    wire lock_clash = i2c_guard_wr && (i2c_byte == i_rf_req.sel);
    wire rf_lock_go = rf_go && i_rf_req.cmd == RF_LOCK && rf_lock_ok &&
                      !lock_clash;

    logic rf_ok;
    always_comb begin
        rf_ok = 1'b0;
        case (i_rf_req.cmd)
            RF_READ: rf_ok = rf_acc[1];
            RF_WRITE: rf_ok = rf_acc[0];
            RF_LOCK: rf_ok = rf_lock_ok && !lock_clash;
            RF_PW_WRITE: rf_ok = rf_pw_wr_ok;
            RF_PW_PRESENT: rf_ok = rf_pw_hit;
            default: rf_ok = 1'b0;
        endcase
    end

    // guard bytes: i2c write and rf lock in one place, no double driver
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int s = 0; s < NUM_SECTORS; s++) begin
                guard[s] <= GUARD_BYTE_RESET;
            end
        end else begin
            for (int s = 0; s < NUM_SECTORS; s++) begin
                // new byte takes effect for rf decisions from the next cycle
                if (i2c_guard_wr && i2c_byte == 2'(s)) begin
                    guard[s] <= i_i2c_req.wdata &
                                GUARD_USED_MASK;
                end else if (rf_lock_go && i_rf_req.sel == 2'(s)) begin
                    guard[s] <= {3'h0, i_rf_req.lock_bits,
                                 1'b1};
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int p = 0; p < NUM_PASSWORDS; p++) begin
                password[p] <= PASSWORD_RESET;
            end
        end else if (rf_go && i_rf_req.cmd == RF_PW_WRITE && rf_pw_wr_ok) begin
            password[rf_pw_idx] <= i_rf_req.data;
        end
    end

    // rights are volatile; reset models power loss
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            granted <= 3'h0;
        end else if (rf_go && i_rf_req.cmd == RF_PW_PRESENT) begin
            if (rf_pw_hit) begin
                granted <= 3'h1 << rf_pw_idx;
            end else begin
                granted <= 3'h0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rf_rsp <= '0;
        end else if (i_ce) begin
            o_rf_rsp.valid <= i_rf_req.valid;
            o_rf_rsp.ok <= rf_ok;
            o_rf_rsp.read_ok <= rf_acc[1];
            o_rf_rsp.write_ok <= rf_acc[0];
            o_rf_rsp.with_guard <= i_rf_req.cmd == RF_READ &&
                                   i_rf_req.option;
            o_rf_rsp.guard <= rf_guard;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_i2c_rsp <= '0;
        end else if (i_ce) begin
            o_i2c_rsp.valid <= i_i2c_req.valid;
            o_i2c_rsp.ok <= !i_i2c_req.write || !i2c_guard_area ||
                            i_i2c_req.pw_ok;
            o_i2c_rsp.write_ok <= i2c_acc[0];
            o_i2c_rsp.rdata <= i2c_guard_area ? i2c_guard_rd : 8'h00;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_guard_word <= 32'h0000_0000;
        end else if (i_ce) begin
            o_guard_word <= {guard[3], guard[2], guard[1], guard[0]};
        end
    end

    a_unlock_open: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && !rf_guard[LOCK_BIT]
        |=> o_rf_rsp.read_ok && o_rf_rsp.write_ok)
        else $error("unlocked sector not open");
    a_prot_none: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && rf_guard[LOCK_BIT] && rf_guard[SEL_LSB +: 2] == SEL_NONE &&
        rf_guard[2] |=> !o_rf_rsp.read_ok)
        else $error("protected sector readable");
    a_pw_ro: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && rf_guard[LOCK_BIT] && rf_guard[PROT_LSB +: 2] == PROT_PW_RO
        |=> !o_rf_rsp.write_ok)
        else $error("read-only sector writable");
    a_pw_select: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && rf_guard[LOCK_BIT] && rf_guard[SEL_LSB +: 2] == SEL_NONE &&
        rf_guard[PROT_LSB +: 2] == PROT_RO_NOPW
        |=> o_rf_rsp.read_ok && !o_rf_rsp.write_ok)
        else $error("unlinked sector access wrong");
    a_guard_echo: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_READ && i_rf_req.option
        |=> o_rf_rsp.with_guard && o_rf_rsp.guard == $past(rf_guard))
        else $error("guard byte not returned");
    a_rsp_valid: assert property ( // answer one cycle on
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go |=> o_rf_rsp.valid)
        else $error("rf answer missing");
    a_lock_sets: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_LOCK && rf_lock_ok && !i2c_guard_wr
        |=> guard[$past(i_rf_req.sel)][LOCK_BIT])
        else $error("lock bit not set");
    a_lock_value: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_LOCK && rf_lock_ok && !i2c_guard_wr
        |=> guard[$past(i_rf_req.sel)] ==
            {3'h0, $past(i_rf_req.lock_bits), 1'b1})
        else $error("lock byte wrong");
    a_lock_err: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_LOCK && !rf_lock_ok
        |=> !o_rf_rsp.ok)
        else $error("relock not refused");
    a_bad_present: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_PRESENT && !rf_pw_hit
        |=> granted == 3'h0)
        else $error("rights kept after bad password");
    a_good_present: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_PRESENT && rf_pw_hit
        |=> granted != 3'h0)
        else $error("rights not granted");
    a_one_right: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_PRESENT && rf_pw_hit
        |=> $onehot(granted))
        else $error("more than one password granted");
    a_pw_block: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_PRESENT && !rf_pw_block
        |=> !o_rf_rsp.ok && granted == 3'h0)
        else $error("present outside password blocks accepted");
    a_pw_guarded: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_WRITE && rf_pw_block &&
        !granted[rf_pw_idx]
        |=> password[$past(rf_pw_idx)] == $past(password[rf_pw_idx]))
        else $error("password changed without present");
    a_pw_refused: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_WRITE && !rf_pw_wr_ok
        |=> !o_rf_rsp.ok)
        else $error("password write not refused");
    a_pw_stored: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_WRITE && rf_pw_wr_ok
        |=> password[$past(rf_pw_idx)] == $past(i_rf_req.data))
        else $error("password not stored");
    a_i2c_nowr: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i2c_go && i_i2c_req.write && i2c_guard_area && !i_i2c_req.pw_ok
        |=> !o_i2c_rsp.ok)
        else $error("i2c guard write without password");
    a_i2c_rdfree: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i2c_go && !i_i2c_req.write && i2c_guard_area
        |=> o_i2c_rsp.ok && o_i2c_rsp.rdata == $past(i2c_guard_rd))
        else $error("i2c guard read refused");
    a_i2c_area: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i2c_go && !i_i2c_req.area_select_bit
        |=> o_i2c_rsp.rdata == 8'h00)
        else $error("guard byte outside its area");
    a_i2c_lands: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i2c_guard_wr
        |=> guard[$past(i2c_byte)] == ($past(i_i2c_req.wdata) &
            GUARD_USED_MASK))
        else $error("i2c guard write lost");
    a_sector_map: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        i2c_go && !guard[i_i2c_req.addr[8:7]][LOCK_BIT]
        |=> o_i2c_rsp.write_ok)
        else $error("unlocked i2c sector not writable");
    a_ce_freeze: assert property ( // clock enable low holds guard word, rights and rf answer
        @(posedge i_mclk) disable iff (!i_resetn)
        !i_ce |=> $stable(o_guard_word) && $stable(granted) &&
        $stable(o_rf_rsp))
        else $error("state moved while disabled");
    a_reset_none: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        $rose(i_resetn) |-> granted == 3'h0)
        else $error("rights present after power-up");
    a_guard_top: assert property (
        @(posedge i_mclk) disable iff (!i_resetn)
        o_guard_word[31:29] == 3'h0 && o_guard_word[7:5] == 3'h0)
        else $error("reserved guard bits set");

    c_lock: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_LOCK && rf_lock_ok);
    c_present: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_PRESENT && rf_pw_hit);
    c_pwwrite: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_PW_WRITE && rf_pw_wr_ok);
    c_i2cwr: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        i2c_guard_wr);
    c_relock: cover property (@(posedge i_mclk) disable iff (!i_resetn)
        rf_go && i_rf_req.cmd == RF_LOCK && !rf_lock_ok);
endmodule : rf_sector_password_guard
`default_nettype wire

// *** dv/sector_host_model.sv ***
// Purpose: reader and i2c master stand-in driving request strobes
// Assumes: requests launched just after a rising edge
// Notes: valid is held for exactly one edge, then dropped
`timescale 1ns/1ps
`default_nettype none
module sector_host_model (
    input wire logic i_mclk,
    output var sector_guard_pkg::rf_req_t o_rf_req,
    output var sector_guard_pkg::i2c_req_t o_i2c_req
);
    import sector_guard_pkg::*;
    initial begin
        o_rf_req = '0;
        o_i2c_req = '0;
    end
    // bench only changes a password after presenting it
    task automatic rf(input rf_cmd_t c, input logic [6:0] b,
        input logic [1:0] s, input logic [3:0] x, input logic [31:0] d);
        @(posedge i_mclk);
        o_rf_req <= '{1'b1, c, b, s, x, 1'b1, d};
        @(posedge i_mclk);
        o_rf_req.valid <= 1'b0;
        #1;
    endtask : rf
    // caller raises the area select bit for guard bytes
    task automatic i2c(input logic w, input logic a, input logic [8:0] ad,
        input logic [7:0] wd, input logic p);
        @(posedge i_mclk);
        o_i2c_req <= '{1'b1, w, a, ad, wd, p};
        @(posedge i_mclk);
        o_i2c_req <= '0;
        #1;
    endtask : i2c
endmodule : sector_host_model
`default_nettype wire

// *** dv/tb_rf_sector_password_guard.sv ***
// Purpose: self-checking bench for rf_sector_password_guard
// Assumes: clock enable held high except in t_ce; one request in flight at a time
// Notes: expected access is rebuilt from the guard bytes kept here
`timescale 1ns/1ps
`default_nettype none
module tb_rf_sector_password_guard;
    import sector_guard_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic ce = 1'b1;
    rf_req_t rq;
    i2c_req_t iq;
    rf_rsp_t rs;
    i2c_rsp_t is;
    logic [31:0] gw;
    logic [7:0] g [4] = '{8'h0, 8'h0, 8'h0, 8'h0};
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    always #2 i_mclk = ~i_mclk;
    sector_host_model i_host (.i_mclk(i_mclk), .o_rf_req(rq),
        .o_i2c_req(iq));
    rf_sector_password_guard i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_ce(ce), .i_rf_req(rq), .i_i2c_req(iq), .o_rf_rsp(rs),
        .o_i2c_rsp(is), .o_guard_word(gw));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [1:0] acc(input logic [7:0] b, input int p);
        logic have;
        have = b[4:3] != 2'h0 && b[4:3] == p[1:0];
        if (!b[0]) return 2'h3;
        case (b[2:1])
            2'h0: return have ? 2'h3 : 2'h2;
            2'h1: return 2'h3;
            2'h2: return have ? 2'h3 : 2'h0;
            default: return have ? 2'h2 : 2'h0;
        endcase
    endfunction : acc
    task automatic sweep(input int p);
        for (int s = 0; s < 4; s++) begin
            i_host.rf(RF_READ, 7'(s * 32), 2'h0, 4'h0, 32'h0);
            chk(32'({rs.read_ok, rs.write_ok}), 32'(acc(g[s], p)));
            chk(32'({rs.with_guard, rs.guard}), {23'h0, 1'b1, g[s]});
        end
    endtask : sweep
    task automatic word;
        @(posedge i_mclk);
        #1;
        chk(gw, {g[3], g[2], g[1], g[0]});
    endtask : word
    task automatic pw(input rf_cmd_t c, input int n, input logic [31:0] d,
        input logic e);
        i_host.rf(c, 7'(n), 2'h0, 4'h0, d);
        chk(32'(rs.ok), 32'(e));
        chk(32'(rs.valid), 32'h1);
    endtask : pw
    task automatic t_reset;
        chk(gw, 32'h0);
        sweep(0);
    endtask : t_reset
    task automatic t_pw;
        pw(RF_PW_PRESENT, 1, 32'h0, 1'b1);
        pw(RF_PW_WRITE, 1, 32'h1234_5678, 1'b1);
        pw(RF_PW_PRESENT, 1, 32'h0, 1'b0);
        pw(RF_PW_WRITE, 1, 32'h0, 1'b0);
        pw(RF_PW_PRESENT, 1, 32'h1234_5678, 1'b1);
    endtask : t_pw
    task automatic t_lock;
        for (int s = 0; s < 4; s++) begin
            g[s] = {3'h0, 2'(s), 2'(s), 1'b1};
            i_host.rf(RF_LOCK, 7'h0, 2'(s), {2'(s), 2'(s)}, 32'h0);
            chk(32'(rs.ok), 32'h1);
        end
        i_host.rf(RF_LOCK, 7'h0, 2'h2, 4'h0, 32'h0);
        chk(32'(rs.ok), 32'h0);
        word();
    endtask : t_lock
    task automatic t_access;
        sweep(1);
        pw(RF_PW_PRESENT, 2, 32'h0, 1'b1);
        sweep(2);
        pw(RF_PW_PRESENT, 3, 32'h0, 1'b1);
        sweep(3);
        pw(RF_PW_PRESENT, 3, 32'h1, 1'b0);
        sweep(0);
    endtask : t_access
    task automatic t_i2c;
        for (int s = 0; s < 4; s++) begin
            i_host.i2c(1'b0, 1'b1, 9'(s), 8'h0, 1'b0);
            chk(32'(is.rdata), 32'(g[s]));
        end
        chk(32'(is.valid), 32'h1);
        chk(32'(is.write_ok), 32'(acc(g[0], 0)) & 32'h1);
        i_host.i2c(1'b1, 1'b1, 9'h2, 8'hff, 1'b0);
        chk(32'(is.ok), 32'h0);
        i_host.i2c(1'b1, 1'b1, 9'h2, 8'hff, 1'b1);
        chk(32'(is.ok), 32'h1);
        g[2] = 8'h1f;
        i_host.i2c(1'b1, 1'b1, 9'h3, 8'h0, 1'b1);
        g[3] = 8'h0;
        i_host.i2c(1'b0, 1'b0, 9'h100, 8'h0, 1'b0);
        chk(32'(is.write_ok), 32'(acc(g[2], 0)) & 32'h1);
        chk(32'(is.rdata), 32'h0);
        i_host.i2c(1'b0, 1'b0, 9'h180, 8'h0, 1'b0);
        chk(32'(is.write_ok), 32'(acc(g[3], 0)) & 32'h1);
        word();
        sweep(0);
    endtask : t_i2c
    // a guard write offered while disabled must leave no trace
    task automatic t_ce;
        @(posedge i_mclk);
        ce <= 1'b0;
        i_host.i2c(1'b1, 1'b1, 9'h0, 8'h1e, 1'b1);
        word();
        @(posedge i_mclk);
        ce <= 1'b1;
        word();
    endtask : t_ce
    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // generous ceiling: the whole flow needs about a hundred cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_reset();
        t_pw();
        t_lock();
        t_access();
        t_i2c();
        t_ce();
        summarize();
    end
endmodule : tb_rf_sector_password_guard
`default_nettype wire
